// file: hw/comb_fir_channel.sv
// channel back end: comb decimator feeding a coefficient-memory fir, apb regs
// Contract
// - input spacing limited by channel rate factor
// - comb ratio programmable from 2 to 32
// - five integrate-comb sections, gain two^-(s+5)
// - scale 0 to 20, each step one shift
// - one comb output per ratio inputs
// - comb accepts an input every clock, every second clock in diversity mode
// - store keeps 160 newest 20-bit iq samples
// - coefficient memory holds 256 20-bit words
// - one i and q tap per clock
// - outputs are 24-bit i and q words
// - fir ratio held as value minus one
// - decimation counter preloaded from phase register
// - tap count minus one, at most 160
// - window coefficients are 20-bit two's complement
// - low coefficient addresses meet older samples
// - two 128-word pages form one array
// - 160 by 40 circular sample store
// - start at offset with oldest sample
// - offset change selects stored coefficient set
// - one fir output per ratio comb outputs
// - page bit clear low half, set high
//
// Local design decision: the APB slave port.
`default_nettype none
`include "comb_fir_defs.svh"
module comb_fir_channel #(
  parameter int DEPTH = `STORE_DEPTH // sample store depth, at most 256
) (
  input wire logic pclk, // processing clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped word
  input wire logic in_valid, // sample strobe from resampling stage
  input wire comb_fir_pkg::iq20_s in_sample, // i and q input sample
  output logic out_valid, // fir output strobe
  output comb_fir_pkg::iq24_s out_sample // fir output sample
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [7:0] fir_decimation_minus_one;
  logic [7:0] fir_decimation_phase;
  logic [7:0] fir_tap_count_minus_one;
  logic [7:0] fir_coefficient_start_offset;
  logic page;
  logic [5:0] comb_decimation_ratio;
  logic [4:0] comb_scale_factor;
  logic diversity;
  logic overrun;
  logic clash;

  logic signed [`SAMPLE_W-1:0] coef_mem [0:`COEF_DEPTH-1];
  comb_fir_pkg::iq20_s store_mem [0:DEPTH-1];

  logic [7:0] idx;
  logic in_win;
  logic in_regs;
  logic mapped;
  logic setup;
  logic wr;
  logic clr_wr;
  logic [31:0] rd_word;

  logic [5:0] ratio_eff;
  logic [4:0] scale_eff;
  logic prev_acc;
  logic accept;
  logic drop;

  logic signed [`SAMPLE_W-1:0] lane_in [0:1];
  logic signed [`SAMPLE_W-1:0] lane_out [0:1];
  logic [1:0] lane_v;
  logic new_sample;

  logic [7:0] wp;
  logic [7:0] dec_cnt;
  logic [7:0] taps_last;
  logic [7:0] oldest;
  logic start;
  logic clash_ev;

  comb_fir_pkg::fir_state_e state;
  logic [7:0] rd;
  logic [7:0] ca;
  logic [7:0] tap;
  comb_fir_pkg::iq20_s cur;
  logic signed [`SAMPLE_W-1:0] coef_cur;
  logic signed [2*`SAMPLE_W-1:0] prod_i;
  logic signed [2*`SAMPLE_W-1:0] prod_q;
  logic signed [`ACC_W-1:0] acc_i;
  logic signed [`ACC_W-1:0] acc_q;

  // apb decode: word index is paddr[9:2], zero wait states
  assign idx = paddr[9:2];
  assign in_win = idx <= `COEF_WIN_LAST;
  assign in_regs = (idx >= `IDX_FIR_DEC) && (idx <= `IDX_STATUS);
  assign mapped = (paddr[11:10] == 2'b00) && (in_win || in_regs);
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && mapped;
  assign clr_wr = wr && (idx == `IDX_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fir_decimation_minus_one <= `FIR_REG_RST;
      fir_decimation_phase <= `FIR_REG_RST;
      fir_tap_count_minus_one <= `FIR_REG_RST;
      fir_coefficient_start_offset <= `FIR_REG_RST;
      page <= 1'b0;
      comb_decimation_ratio <= `COMB_RATIO_RST;
      comb_scale_factor <= 5'd0;
      diversity <= 1'b0;
    end else if (wr) begin
      case (idx)
        `IDX_FIR_DEC: fir_decimation_minus_one <= pwdata[7:0];
        `IDX_FIR_PHASE: fir_decimation_phase <= pwdata[7:0];
        `IDX_FIR_TAPS: fir_tap_count_minus_one <= pwdata[7:0];
        `IDX_FIR_OFFSET: fir_coefficient_start_offset <= pwdata[7:0];
        `IDX_FIR_CTRL: page <= pwdata[`PAGE_BIT];
        `IDX_COMB_CTRL: begin
          comb_decimation_ratio <= pwdata[`COMB_RATIO_F];
          comb_scale_factor <= pwdata[`COMB_SCALE_F];
          diversity <= pwdata[`DIVERSITY_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // page bit forms the top address bit of the coefficient memory
  always_ff @(posedge pclk) begin
    if (wr && in_win) begin
      coef_mem[{page, idx[6:0]}] <= pwdata[`SAMPLE_W-1:0];
    end
  end

  always_comb begin
    rd_word = '0;
    case (idx)
      `IDX_FIR_DEC: rd_word[7:0] = fir_decimation_minus_one;
      `IDX_FIR_PHASE: rd_word[7:0] = fir_decimation_phase;
      `IDX_FIR_TAPS: rd_word[7:0] = fir_tap_count_minus_one;
      `IDX_FIR_OFFSET: rd_word[7:0] = fir_coefficient_start_offset;
      `IDX_FIR_CTRL: rd_word[`PAGE_BIT] = page;
      `IDX_COMB_CTRL: begin
        rd_word[`COMB_RATIO_F] = comb_decimation_ratio;
        rd_word[`COMB_SCALE_F] = comb_scale_factor;
        rd_word[`DIVERSITY_BIT] = diversity;
      end
      `IDX_STATUS: begin
        rd_word[`ST_BUSY_BIT] = state != comb_fir_pkg::st_idle;
        rd_word[`ST_OVERRUN_BIT] = overrun;
        rd_word[`ST_CLASH_BIT] = clash;
        rd_word[`ST_WP_F] = wp;
      end
      default: begin
        if (in_win) begin
          rd_word[`SAMPLE_W-1:0] = coef_mem[{page, idx[6:0]}];
        end
      end
    endcase
  end

  // read data is captured in the setup cycle and stands through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      prdata <= rd_word;
    end
  end

  // sticky flags: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= 1'b0;
      clash <= 1'b0;
    end else begin
      overrun <= drop | (overrun & ~(clr_wr & pwdata[`ST_OVERRUN_BIT]));
      clash <= clash_ev | (clash & ~(clr_wr & pwdata[`ST_CLASH_BIT]));
    end
  end

  // out-of-range settings are clamped to the nearest legal value
  assign ratio_eff = (comb_decimation_ratio < `COMB_RATIO_MIN) ? `COMB_RATIO_MIN :
                     (comb_decimation_ratio > `COMB_RATIO_MAX) ? `COMB_RATIO_MAX :
                     comb_decimation_ratio;
  assign scale_eff = (comb_scale_factor > `COMB_SCALE_MAX) ? `COMB_SCALE_MAX
                                                           : comb_scale_factor;

  // diversity mode halves the admissible input rate; excess samples are dropped
  assign accept = in_valid && !(diversity && prev_acc);
  assign drop = in_valid && !accept;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_acc <= 1'b0;
    end else begin
      prev_acc <= accept;
    end
  end

  assign lane_in[0] = in_sample.i;
  assign lane_in[1] = in_sample.q;

  for (genvar c = 0; c < 2; c++) begin : g_lane
    comb_decimator #(
      .IN_W(`SAMPLE_W),
      .ACC_W(`COMB_ACC_W),
      .OUT_W(`SAMPLE_W)
    ) u_comb (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(accept),
      .in_data(lane_in[c]),
      .ratio(ratio_eff),
      .scale(scale_eff),
      .out_valid(lane_v[c]),
      .out_data(lane_out[c])
    );
  end

  assign new_sample = lane_v[0];

  always_ff @(posedge pclk) begin
    if (new_sample) begin
      store_mem[wp] <= {lane_out[0], lane_out[1]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp <= 8'h00;
    end else if (new_sample) begin
      wp <= (wp == 8'(DEPTH - 1)) ? 8'h00 : wp + 8'h01;
    end
  end

  // a computation starts on the sample that completes the decimation count
  assign start = new_sample && (dec_cnt == fir_decimation_minus_one);
  assign clash_ev = start && (state != comb_fir_pkg::st_idle);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_cnt <= 8'h00;
    end else if (wr && (idx == `IDX_FIR_PHASE)) begin
      dec_cnt <= pwdata[7:0];
    end else if (new_sample) begin
      dec_cnt <= start ? 8'h00 : dec_cnt + 8'h01;
    end
  end

  assign taps_last = (fir_tap_count_minus_one > 8'(DEPTH - 1)) ? 8'(DEPTH - 1)
                                                               : fir_tap_count_minus_one;
  // the newest sample is written at wp in the start cycle
  assign oldest = (wp >= taps_last) ? wp - taps_last
                                    : 8'(DEPTH) - taps_last + wp;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= comb_fir_pkg::st_idle;
    end else begin
      case (state)
        comb_fir_pkg::st_idle: begin
          if (start) begin
            state <= comb_fir_pkg::st_mac;
          end
        end
        comb_fir_pkg::st_mac: begin
          if (tap == taps_last) begin
            state <= comb_fir_pkg::st_emit;
          end
        end
        comb_fir_pkg::st_emit: state <= comb_fir_pkg::st_idle;
        default: state <= comb_fir_pkg::st_idle;
      endcase
    end
  end

  // coefficient address wraps across both pages as one array
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd <= 8'h00;
      ca <= 8'h00;
      tap <= 8'h00;
    end else if (state == comb_fir_pkg::st_idle && start) begin
      rd <= oldest;
      ca <= fir_coefficient_start_offset;
      tap <= 8'h00;
    end else if (state == comb_fir_pkg::st_mac) begin
      rd <= (rd == 8'(DEPTH - 1)) ? 8'h00 : rd + 8'h01;
      ca <= ca + 8'h01;
      tap <= tap + 8'h01;
    end
  end

  assign cur = store_mem[rd];
  assign coef_cur = coef_mem[ca];
  assign prod_i = cur.i * coef_cur;
  assign prod_q = cur.q * coef_cur;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_i <= '0;
      acc_q <= '0;
    end else if (state == comb_fir_pkg::st_idle && start) begin
      acc_i <= '0;
      acc_q <= '0;
    end else if (state == comb_fir_pkg::st_mac) begin
      acc_i <= acc_i + `ACC_W'(prod_i);
      acc_q <= acc_q + `ACC_W'(prod_q);
    end
  end

  function automatic logic signed [`OUT_W-1:0] sat24(input logic signed [`ACC_W-1:0] a);
    logic signed [`ACC_W-1:0] s;
    s = a >>> `FIR_OUT_SHIFT;
    if ((&s[`ACC_W-1:`OUT_W-1]) || !(|s[`ACC_W-1:`OUT_W-1])) begin
      sat24 = s[`OUT_W-1:0];
    end else begin
      sat24 = {s[`ACC_W-1], {(`OUT_W-1){~s[`ACC_W-1]}}};
    end
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_sample <= '0;
    end else begin
      out_valid <= state == comb_fir_pkg::st_emit;
      if (state == comb_fir_pkg::st_emit) begin
        out_sample <= {sat24(acc_i), sat24(acc_q)};
      end
    end
  end

  div_spacing_a: assert property (
    diversity && accept ##1 diversity |-> !accept)
    else $error("diversity mode accepted inputs back to back");

  comb_ratio_range_a: assert property (
    ratio_eff >= `COMB_RATIO_MIN && ratio_eff <= `COMB_RATIO_MAX)
    else $error("comb ratio outside 2 to 32");

  comb_scale_range_a: assert property (
    scale_eff <= `COMB_SCALE_MAX)
    else $error("comb scale above 20");

  phase_preload_a: assert property (
    wr && idx == `IDX_FIR_PHASE |=> dec_cnt == $past(pwdata[7:0]))
    else $error("decimation counter not preloaded from phase");

  start_point_a: assert property (
    state == comb_fir_pkg::st_idle && start |=>
      state == comb_fir_pkg::st_mac && tap == 8'h00 && ca == $past(fir_coefficient_start_offset))
    else $error("computation did not start at offset");

  tap_step_a: assert property (
    state == comb_fir_pkg::st_mac && tap != taps_last |=>
      state == comb_fir_pkg::st_mac && tap == $past(tap) + 8'h01 && ca == $past(ca) + 8'h01)
    else $error("tap not advanced by one per clock");

  result_emit_a: assert property (
    state == comb_fir_pkg::st_mac && tap == taps_last |=> !out_valid ##1 out_valid)
    else $error("result not presented after last tap");

  store_ptr_a: assert property (
    wp < 8'(DEPTH) && rd < 8'(DEPTH))
    else $error("store pointer outside circular buffer");
endmodule // comb_fir_channel
`default_nettype wire

// file: hw/comb_fir_defs.svh
// offsets, fields, reset values and sizes of the comb and fir channel
`ifndef COMB_FIR_DEFS_SVH
`define COMB_FIR_DEFS_SVH
`define COEF_WIN_LAST 8'h7f
`define IDX_FIR_DEC 8'ha0
`define IDX_FIR_PHASE 8'ha1
`define IDX_FIR_TAPS 8'ha2
`define IDX_FIR_OFFSET 8'ha3
`define IDX_FIR_CTRL 8'ha4
`define IDX_COMB_CTRL 8'ha5
`define IDX_STATUS 8'ha6
`define PAGE_BIT 8
`define COMB_RATIO_F 5:0
`define COMB_SCALE_F 12:8
`define DIVERSITY_BIT 16
`define ST_BUSY_BIT 0
`define ST_OVERRUN_BIT 1
`define ST_CLASH_BIT 2
`define ST_WP_F 15:8
`define FIR_REG_RST 8'h00
`define COMB_RATIO_RST 6'd2
`define COMB_RATIO_MIN 6'd2
`define COMB_RATIO_MAX 6'd32
`define COMB_SCALE_MAX 5'd20
`define COMB_GAIN_SHIFT 6'd5
`define COMB_ORDER 5
`define COMB_ACC_W 45
`define SAMPLE_W 20
`define OUT_W 24
`define ACC_W 48
`define FIR_OUT_SHIFT 19
`define STORE_DEPTH 160
`define COEF_DEPTH 256
`endif

// file: hw/comb_fir_pkg.sv
// shared sample and state types of the comb and fir channel
`default_nettype none
`include "comb_fir_defs.svh"
package comb_fir_pkg;
  typedef struct packed {
    logic signed [`SAMPLE_W-1:0] i;
    logic signed [`SAMPLE_W-1:0] q;
  } iq20_s;
  typedef struct packed {
    logic signed [`OUT_W-1:0] i;
    logic signed [`OUT_W-1:0] q;
  } iq24_s;
  typedef enum logic [1:0] {st_idle, st_mac, st_emit} fir_state_e;
endpackage
`default_nettype wire

// file: hw/comb_decimator.sv
// fifth-order integrate and comb decimator for one real lane
`default_nettype none
`include "comb_fir_defs.svh"
module comb_decimator #(
  parameter int IN_W = `SAMPLE_W,
  parameter int ACC_W = `COMB_ACC_W,
  parameter int OUT_W = `SAMPLE_W
) (
  input wire logic pclk, // processing clock
  input wire logic presetn, // async reset, active low
  input wire logic in_valid, // input sample strobe
  input wire logic signed [IN_W-1:0] in_data, // input sample
  input wire logic [5:0] ratio, // decimation ratio, 2 to 32
  input wire logic [4:0] scale, // attenuation in right shifts
  output logic out_valid, // one-cycle output strobe
  output logic signed [OUT_W-1:0] out_data // decimated sample
);
  logic signed [ACC_W-1:0] integ [1:`COMB_ORDER];
  logic signed [ACC_W-1:0] diff [1:`COMB_ORDER];
  logic signed [ACC_W-1:0] in_ext;
  logic signed [ACC_W-1:0] shifted;
  logic [5:0] phase;
  logic [5:0] shamt;
  logic tick;
  logic fits;

  assign in_ext = {{(ACC_W-IN_W){in_data[IN_W-1]}}, in_data};
  assign tick = in_valid && (phase >= ratio - 6'd1);

  for (genvar k = 1; k <= `COMB_ORDER; k++) begin : g_sec
    logic signed [ACC_W-1:0] ifeed;
    logic signed [ACC_W-1:0] cfeed;
    logic signed [ACC_W-1:0] dly;
    if (k == 1) begin : g_first
      assign ifeed = in_ext;
      assign cfeed = integ[`COMB_ORDER];
    end else begin : g_next
      assign ifeed = integ[k-1];
      assign cfeed = diff[k-1];
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        integ[k] <= '0;
      end else if (in_valid) begin
        integ[k] <= integ[k] + ifeed;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dly <= '0;
      end else if (tick) begin
        dly <= cfeed;
      end
    end
    assign diff[k] = cfeed - dly;
  end

  // wrap-around arithmetic makes the full-width result exact before scaling
  assign shamt = {1'b0, scale} + `COMB_GAIN_SHIFT;
  assign shifted = diff[`COMB_ORDER] >>> shamt;
  assign fits = (&shifted[ACC_W-1:OUT_W-1]) | ~(|shifted[ACC_W-1:OUT_W-1]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= '0;
    end else if (in_valid) begin
      phase <= tick ? 6'd0 : phase + 6'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= tick;
      if (tick) begin
        out_data <= fits ? shifted[OUT_W-1:0]
                         : {shifted[ACC_W-1], {(OUT_W-1){~shifted[ACC_W-1]}}};
      end
    end
  end

  // helper: inputs seen since the last output, and ratio changes meanwhile
  logic [5:0] seen;
  logic [5:0] ratio_q;
  logic touched;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= '0;
      ratio_q <= `COMB_RATIO_RST;
      touched <= 1'b1;
    end else begin
      seen <= out_valid ? {5'd0, in_valid} : seen + {5'd0, in_valid};
      ratio_q <= ratio;
      touched <= out_valid ? (ratio != ratio_q) : (touched | (ratio != ratio_q));
    end
  end

  comb_out_rate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    out_valid && !touched |-> seen == ratio)
    else $error("comb output not after ratio inputs");
endmodule // comb_decimator
`default_nettype wire

// file: tb/sample_source.sv
// upstream resampling stage model: paced i and q sample strobes
`default_nettype none
module sample_source (
  input wire logic pclk, // processing clock
  output logic in_valid, // sample strobe
  output comb_fir_pkg::iq20_s in_sample // i and q sample
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    in_valid = 1'b0;
    in_sample = '0;
  end
  // n samples, one every gap cycles; gap 1 is one per clock
  task send(input comb_fir_pkg::iq20_s s, input int gap, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge pclk);
      in_valid <= 1'b1;
      in_sample <= s;
      repeat (gap - 1) begin
        @(posedge pclk);
        in_valid <= 1'b0;
        in_sample <= ~s;
      end
    end
    @(posedge pclk);
    in_valid <= 1'b0;
    // released data shows the inverse so stale values never match
    in_sample <= ~s;
  endtask
endmodule // sample_source
`default_nettype wire

// file: tb/tb_comb_fir_channel.sv
// self-checking bench of the comb decimator and coefficient fir channel
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_comb_fir_channel;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic in_valid;
  comb_fir_pkg::iq20_s in_sample;
  logic out_valid;
  comb_fir_pkg::iq24_s out_sample;
  comb_fir_pkg::iq24_s last_out;
  comb_fir_pkg::iq20_s x;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int total_checks = 0;
  int n_out = 0;
  int cycles = 0;
  int rt[5] = '{2, 4, 8, 16, 32};
  int gt[5] = '{2, 1, 2, 2, 1};
  always #25 pclk = ~pclk;
  comb_fir_channel #(.DEPTH(160)) u_comb_fir_channel (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
    .in_sample(in_sample), .out_valid(out_valid), .out_sample(out_sample));
  sample_source u_sample_source (.pclk(pclk), .in_valid(in_valid), .in_sample(in_sample));
  task summarize();
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (out_valid === 1'b1) begin
      last_out = out_sample;
      n_out++;
    end
    if (cycles == 60000) begin
      fails++;
      summarize();
    end
  end
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask
  task rchk(input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h00000000);
    `CHK(rd, e)
  endtask
  // settle on dc, then count outputs over four comb outputs and check the level
  task dc_run(input logic [5:0] r, input logic [4:0] s, input int gap,
      input logic [47:0] e);
    int base;
    wr(8'ha5, {19'h00000, s, 2'b00, r});
    u_sample_source.send(x, gap, 8 * r);
    repeat (12) @(posedge pclk);
    base = n_out;
    u_sample_source.send(x, gap, 4 * r);
    repeat (12) @(posedge pclk);
    `CHK(n_out - base, 4)
    `CHK(last_out, e)
  endtask
  // samples needed until the first output after a phase load
  task phase_run(input logic [7:0] p, input int exp_n);
    int n;
    int base;
    wr(8'ha1, {24'h000000, p});
    n = 0;
    base = n_out;
    while (n_out == base && n < 20) begin
      u_sample_source.send(x, 1, 1);
      n++;
      repeat (8) @(posedge pclk);
    end
    `CHK(n, exp_n)
  endtask
  initial begin
    x.i = 20'hffc18;
    x.q = 20'h00309;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk(8'ha0, 32'h00000000);
    rchk(8'ha1, 32'h00000000);
    rchk(8'ha2, 32'h00000000);
    rchk(8'ha3, 32'h00000000);
    rchk(8'ha4, 32'h00000000);
    rchk(8'ha5, 32'h00000002);
    apb(1'b0, 8'h80, 32'h00000000);
    `CHK({err, rd}, 33'h100000000)
    wr(8'ha2, 32'h000000ff);
    rchk(8'ha2, 32'h000000ff);
    wr(8'ha5, 32'h00001928);
    rchk(8'ha5, 32'h00001928);
    wr(8'ha5, 32'h00000001);
    rchk(8'ha5, 32'h00000001);
    wr(8'h00, 32'h00080000);
    wr(8'h05, 32'h00040000);
    wr(8'h08, 32'h00020000);
    wr(8'h09, 32'h00020000);
    wr(8'h0a, 32'h00040000);
    wr(8'h7f, 32'h00040000);
    wr(8'ha4, 32'h00000100);
    wr(8'h00, 32'h00040000);
    wr(8'h01, 32'h00080000);
    rchk(8'h01, 32'h00080000);
    rchk(8'h00, 32'h00040000);
    wr(8'ha4, 32'h00000000);
    rchk(8'h00, 32'h00080000);
    wr(8'ha2, 32'h00000000);
    wr(8'ha0, 32'h00000003);
    phase_run(8'h03, 2);
    phase_run(8'h01, 6);
    phase_run(8'h00, 8);
    wr(8'ha0, 32'h00000000);
    // coefficient 0 is -2^19, so the single tap negates the comb output
    for (int k = 0; k < 5; k++)
      dc_run(6'(rt[k]), 5'(5 * k), gt[k], 48'h0003e8fffcf7);
    wr(8'ha3, 32'h00000005);
    dc_run(6'h04, 5'h05, 1, 48'hfffe0c000184);
    wr(8'ha3, 32'h00000008);
    wr(8'ha2, 32'h00000002);
    dc_run(6'h04, 5'h05, 2, 48'hfffc18000309);
    wr(8'ha3, 32'h0000007f);
    wr(8'ha2, 32'h00000001);
    dc_run(6'h04, 5'h05, 2, 48'hfffc18000309);
    wr(8'ha3, 32'h00000080);
    dc_run(6'h04, 5'h05, 2, 48'h0001f4fffe7b);
    wr(8'ha5, 32'h00010204);
    u_sample_source.send(x, 1, 2);
    apb(1'b0, 8'ha6, 32'h00000000);
    `CHK(rd[1], 1'b1)
    wr(8'ha6, 32'h00000002);
    apb(1'b0, 8'ha6, 32'h00000000);
    `CHK(rd[1], 1'b0)
    // comb outputs two cycles apart start the fir while it is still busy
    wr(8'ha5, 32'h00000002);
    u_sample_source.send(x, 1, 4);
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'ha6, 32'h00000000);
    `CHK(rd[2], 1'b1)
    wr(8'ha6, 32'h00000004);
    apb(1'b0, 8'ha6, 32'h00000000);
    `CHK(rd[2], 1'b0)
    summarize();
  end
endmodule // tb_comb_fir_channel
`default_nettype wire
